// ===== mofp_pkg.sv
package mofp_pkg;
   // Register map, bank 0
   localparam logic [7:0] REG_RATE_RATE_RANGE = 8'h4f;
   localparam logic [7:0] REG_ACCEL_RATE_RANGE = 8'h50;
   localparam logic [7:0] REG_RATE_FILT_ORDER = 8'h51;
   localparam logic [7:0] REG_OUT_FILT_BW = 8'h52;
   localparam logic [7:0] REG_ACCEL_FILT_ORDER = 8'h53;
   localparam logic [7:0] REG_QUEUE_CFG = 8'h5f;
   localparam logic [7:0] REG_QUEUE_COUNT_HI = 8'h2e;
   localparam logic [7:0] REG_QUEUE_COUNT_LO = 8'h2f;
   localparam logic [7:0] REG_QUEUE_DATA = 8'h30;
   // Reset values: rate code 0110 (1 kHz), range 000
   localparam logic [7:0] RST_RATE_RATE_RANGE = 8'h06;
   localparam logic [7:0] RST_ACCEL_RATE_RANGE = 8'h06;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // Field positions
   localparam int RATE_CODE_LSB = 0;
   localparam int RANGE_CODE_LSB = 5;
   localparam int RATE_BW_LSB = 0;
   localparam int ACCEL_BW_LSB = 4;
   localparam int RATE_ORD_LSB = 2;
   localparam int ACCEL_ORD_LSB = 3;
   localparam int Q_ACCEL_EN_BIT = 0;
   localparam int Q_RATE_EN_BIT = 1;
   localparam int Q_TIME_EN_BIT = 3;
   // Header bits
   localparam int HDR_EMPTY_BIT = 7;
   localparam int HDR_ACCEL_BIT = 6;
   localparam int HDR_RATE_BIT = 5;
   localparam logic [1:0] HDR_TIMESTAMP = 2'b10;
   localparam int HDR_ACCEL_CHG_BIT = 1;
   localparam int HDR_RATE_CHG_BIT = 0;
   // Packet sizes and storage
   localparam logic [4:0] PKT_SHORT = 5'h08;
   localparam logic [4:0] PKT_LONG = 5'h10;
   localparam int QUEUE_DEPTH = 2048;
   // Rate code encodings, accel range and filter order limits
   localparam logic [3:0] RATE_32K = 4'h1;
   localparam logic [3:0] RATE_12P5 = 4'hb;
   localparam logic [3:0] RATE_500 = 4'hf;
   localparam logic [3:0] RATE_1P5625 = 4'he;
   localparam logic [2:0] ACCEL_RANGE_MAX = 3'h3;
   localparam logic [1:0] ORDER_MAX = 2'h2;

   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } mofp_axes_t;

   typedef struct packed {
      mofp_axes_t accel;
      mofp_axes_t rate;
      logic [7:0] temp;
      logic [15:0] stamp;
   } mofp_sample_t;

   typedef struct packed {
      logic [3:0] rate_output_rate_code;
      logic [2:0] rate_full_scale_code;
      logic [3:0] accel_output_rate_code;
      logic [2:0] accel_full_scale_code;
      logic [3:0] rate_output_filter_bw_code;
      logic [3:0] accel_output_filter_bw_code;
      logic [1:0] rate_output_filter_order;
      logic [1:0] accel_output_filter_order;
   } mofp_cfg_t;
endpackage : mofp_pkg

// ===== mofp_queue.sv
`timescale 1ns/1ps
`default_nettype none
module mofp_queue #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2048,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic rd_en,
   output logic [WIDTH-1:0] rd_data,
   output logic [AW:0] count,
   output logic full
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic do_wr;
   logic do_rd;

   assign do_rd = rd_en && (count_r != '0);
   assign do_wr = wr_en && (count_r != (AW+1)'(DEPTH) || do_rd);
   assign rd_data = mem[rd_ptr_r];
   assign count = count_r;
   assign full = (count_r == (AW+1)'(DEPTH));

   always_ff @(posedge sys_clk) begin
      if (ce && do_wr) begin
         mem[wr_ptr_r] <= wr_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else if (ce) begin
         if (do_wr) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule : mofp_queue
`default_nettype wire

// ===== mofp_top.sv
`timescale 1ns/1ps
`default_nettype none
module mofp_top
   import mofp_pkg::*;
#(
   parameter int DEPTH = QUEUE_DEPTH
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic sample_strobe,
   input wire mofp_pkg::mofp_sample_t sample,
   output mofp_pkg::mofp_cfg_t cfg,
   output logic [16:0] sel_bw_dhz,
   output logic [15:0] sel_delay_dms,
   output logic [15:0] sel_noise_bw_dhz,
   output logic pack_busy
);
   import mofp_pkg::*;

   localparam int AW = $clog2(DEPTH);

   typedef enum logic [1:0] {
      PK_IDLE,
      PK_SEND
   } mofp_pk_state_t;

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] rate_rr_r;
   logic [7:0] accel_rr_r;
   logic [7:0] bw_r;
   logic [7:0] rate_ord_r;
   logic [7:0] accel_ord_r;
   logic [7:0] qcfg_r;
   mofp_pk_state_t pk_state_r;
   logic [4:0] pk_idx_r;
   logic [4:0] pk_len_r;
   logic [127:0] pk_bytes_r;
   logic [3:0] last_accel_rate_r;
   logic [3:0] last_rate_rate_r;
   logic q_wr;
   logic [7:0] q_wdata;
   logic q_rd;
   logic [7:0] q_rdata;
   logic [AW:0] q_count;
   logic q_full;
   logic [15:0] count16;
   logic [7:0] header;
   logic accel_en;
   logic rate_en;
   logic [7:0] rdata_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rate_rr_r <= RST_RATE_RATE_RANGE;
         accel_rr_r <= RST_ACCEL_RATE_RANGE;
         bw_r <= RST_ZERO;
         rate_ord_r <= RST_ZERO;
         accel_ord_r <= RST_ZERO;
         qcfg_r <= RST_ZERO;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            REG_RATE_RATE_RANGE: rate_rr_r <= reg_wdata;
            REG_ACCEL_RATE_RANGE: accel_rr_r <= reg_wdata;
            REG_OUT_FILT_BW: bw_r <= reg_wdata;
            REG_RATE_FILT_ORDER: rate_ord_r <= reg_wdata;
            REG_ACCEL_FILT_ORDER: accel_ord_r <= reg_wdata;
            REG_QUEUE_CFG: qcfg_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration fields
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg <= '0;
      end else if (ce) begin
         cfg.rate_output_rate_code <= rate_rr_r[RATE_CODE_LSB +: 4];
         cfg.rate_full_scale_code <= rate_rr_r[RANGE_CODE_LSB +: 3];
         cfg.accel_output_rate_code <= accel_rr_r[RATE_CODE_LSB +: 4];
         cfg.accel_full_scale_code <= accel_rr_r[RANGE_CODE_LSB +: 3];
         cfg.rate_output_filter_bw_code <= bw_r[RATE_BW_LSB +: 4];
         cfg.accel_output_filter_bw_code <= bw_r[ACCEL_BW_LSB +: 4];
         cfg.rate_output_filter_order <= rate_ord_r[RATE_ORD_LSB +: 2];
         cfg.accel_output_filter_order <= accel_ord_r[ACCEL_ORD_LSB +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Filter figures for the rate channel, tenths of Hz / tenths of ms.
   // Only the documented 1 kHz row plus the 32 kHz point are tabulated;
   // other rates report zero rather than invent figures.
   function automatic logic [16:0] bw_fig(input logic [1:0] ord,
                                          input logic [3:0] rc,
                                          input logic [3:0] bc);
      logic [16:0] v;
      v = 17'h00000;
      if (rc == RATE_32K) begin
         // 32 kHz figure
         // 8400.0 Hz in tenths overflows 16 bits, hence the wider port
         v = 17'h14820;
      end else if (rc == 4'h6) begin
         case ({ord, bc})
            6'h00: v = 17'h01377;
            6'h0f: v = 17'h051e3;
            6'h07: v = 17'h000ef;
            6'h10: v = 17'h01345;
            6'h17: v = 17'h000d5;
            6'h20: v = 17'h01341;
            6'h27: v = 17'h000fc;
            default: v = 17'h00000;
         endcase
      end
      return v;
   endfunction : bw_fig

   function automatic logic [15:0] dly_fig(input logic [1:0] ord,
                                           input logic [3:0] rc,
                                           input logic [3:0] bc);
      logic [15:0] v;
      v = 16'h0000;
      if (rc == 4'h6) begin
         case ({ord, bc})
            6'h07: v = 16'd81;
            6'h17: v = 16'd120;
            6'h27: v = 16'd141;
            default: v = 16'h0000;
         endcase
      end
      return v;
   endfunction : dly_fig

   function automatic logic [15:0] noise_bw_fig(input logic [1:0] ord,
                                           input logic [3:0] rc,
                                           input logic [3:0] bc);
      logic [15:0] v;
      v = 16'h0000;
      if (rc == 4'h6) begin
         case ({ord, bc})
            6'h00: v = 16'd5511;
            6'h11: v = 16'd2237;
            6'h21: v = 16'd2213;
            default: v = 16'h0000;
         endcase
      end
      return v;
   endfunction : noise_bw_fig

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sel_bw_dhz <= '0;
         sel_delay_dms <= '0;
         sel_noise_bw_dhz <= '0;
      end else if (ce) begin
         sel_bw_dhz <= bw_fig(rate_ord_r[RATE_ORD_LSB +: 2],
                              rate_rr_r[3:0], bw_r[3:0]);
         sel_delay_dms <= dly_fig(rate_ord_r[RATE_ORD_LSB +: 2],
                                  rate_rr_r[3:0], bw_r[3:0]);
         sel_noise_bw_dhz <= noise_bw_fig(rate_ord_r[RATE_ORD_LSB +: 2],
                                          rate_rr_r[3:0], bw_r[3:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Packet assembly
   assign accel_en = qcfg_r[Q_ACCEL_EN_BIT];
   assign rate_en = qcfg_r[Q_RATE_EN_BIT];

   always_comb begin
      header = 8'h00;
      header[HDR_ACCEL_BIT] = accel_en;
      header[HDR_RATE_BIT] = rate_en;
      if (accel_en && rate_en) begin
         header[3:2] = HDR_TIMESTAMP;
      end
      header[HDR_ACCEL_CHG_BIT] = accel_en &&
         (accel_rr_r[3:0] != last_accel_rate_r);
      header[HDR_RATE_CHG_BIT] = rate_en &&
         (rate_rr_r[3:0] != last_rate_rate_r);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pk_state_r <= PK_IDLE;
         pk_idx_r <= '0;
         pk_len_r <= '0;
         pk_bytes_r <= '0;
         last_accel_rate_r <= RST_ACCEL_RATE_RANGE[3:0];
         last_rate_rate_r <= RST_RATE_RATE_RANGE[3:0];
      end else if (ce) begin
         case (pk_state_r)
            PK_IDLE: begin
               if (sample_strobe && (accel_en || rate_en)) begin
                  pk_idx_r <= '0;
                  pk_state_r <= PK_SEND;
                  if (accel_en && rate_en) begin
                     pk_len_r <= PKT_LONG;
                     pk_bytes_r <= {header, sample.accel, sample.rate,
                                    sample.temp, sample.stamp};
                  end else begin
                     pk_len_r <= PKT_SHORT;
                     pk_bytes_r <= {header,
                        accel_en ? sample.accel : sample.rate,
                        sample.temp, 64'h0};
                  end
                  if (accel_en) begin
                     last_accel_rate_r <= accel_rr_r[3:0];
                  end
                  if (rate_en) begin
                     last_rate_rate_r <= rate_rr_r[3:0];
                  end
               end
            end
            PK_SEND: begin
               if (!q_full) begin
                  pk_bytes_r <= {pk_bytes_r[119:0], 8'h00};
                  pk_idx_r <= pk_idx_r + 5'h01;
                  if (pk_idx_r == pk_len_r - 5'h01) begin
                     pk_state_r <= PK_IDLE;
                  end
               end
            end
            default: pk_state_r <= PK_IDLE;
         endcase
      end
   end

   // Samples arriving while a packet drains are dropped, never merged
   assign q_wr = (pk_state_r == PK_SEND) && !q_full;
   assign q_wdata = pk_bytes_r[127:120];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pack_busy <= 1'b0;
      end else if (ce) begin
         pack_busy <= (pk_state_r == PK_SEND) ||
                      (sample_strobe && (accel_en || rate_en));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // byte queue
   mofp_queue #(
      .WIDTH(8),
      .DEPTH(DEPTH)
   ) u_queue (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .wr_en(q_wr),
      .wr_data(q_wdata),
      .rd_en(q_rd),
      .rd_data(q_rdata),
      .count(q_count),
      .full(q_full)
   );

   assign q_rd = ce && reg_rd && (reg_addr == REG_QUEUE_DATA);
   assign count16 = 16'(q_count);

   ////////////////////////////////////////////////////////////////////////
   // Register reads, one cycle after the strobe
   always_comb begin
      case (reg_addr)
         REG_RATE_RATE_RANGE: rdata_nxt = rate_rr_r;
         REG_ACCEL_RATE_RANGE: rdata_nxt = accel_rr_r;
         REG_OUT_FILT_BW: rdata_nxt = bw_r;
         REG_RATE_FILT_ORDER: rdata_nxt = rate_ord_r;
         REG_ACCEL_FILT_ORDER: rdata_nxt = accel_ord_r;
         REG_QUEUE_CFG: rdata_nxt = qcfg_r;
         REG_QUEUE_COUNT_HI: rdata_nxt = count16[15:8];
         REG_QUEUE_COUNT_LO: rdata_nxt = count16[7:0];
         // empty marker when nothing is stored
         REG_QUEUE_DATA: rdata_nxt = (q_count == '0) ?
            8'h80 : q_rdata;
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (ce && reg_rd) begin
         reg_rdata <= rdata_nxt;
      end
   end
endmodule : mofp_top
`default_nettype wire

// ===== mofp_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mofp_assertions #(
   parameter int DEPTH = mofp_pkg::QUEUE_DEPTH
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic sample_strobe,
   input wire mofp_pkg::mofp_sample_t sample,
   input wire mofp_pkg::mofp_cfg_t cfg,
   input wire logic [16:0] sel_bw_dhz,
   input wire logic [15:0] sel_delay_dms,
   input wire logic [15:0] sel_noise_bw_dhz,
   input wire logic pack_busy
);
   import mofp_pkg::*;
   logic [7:0] sh_rate_r, sh_accel_r, sh_bw_r, d_rate_r, d_accel_r, d_bw_r;
   logic [1:0] q_en_r;
   logic go_strobe;
   assign go_strobe = sample_strobe && ce && !pack_busy;
   // Shadow of the host-written configuration
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sh_rate_r <= RST_RATE_RATE_RANGE;
         sh_accel_r <= RST_ACCEL_RATE_RANGE;
         sh_bw_r <= RST_ZERO;
         q_en_r <= 2'h0;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            REG_RATE_RATE_RANGE: sh_rate_r <= reg_wdata;
            REG_ACCEL_RATE_RANGE: sh_accel_r <= reg_wdata;
            REG_OUT_FILT_BW: sh_bw_r <= reg_wdata;
            REG_QUEUE_CFG: q_en_r <= reg_wdata[1:0];
            default: ;
         endcase
      end
   end
   // Decoded fields trail the registers by one cycle
   always_ff @(posedge sys_clk) begin
      d_rate_r <= sh_rate_r;
      d_accel_r <= sh_accel_r;
      d_bw_r <= sh_bw_r;
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Busy trails the packer state, so it stays up one cycle past the
   // last queue write: 9 cycles for short packets, 17 for long ones
   sequence seq_busy8;
      pack_busy [*8];
   endsequence
   sequence seq_short;
      seq_busy8 ##1 pack_busy ##1 !pack_busy;
   endsequence
   sequence seq_long;
      seq_busy8 ##1 seq_busy8 ##1 pack_busy ##1 !pack_busy;
   endsequence
   a_short_packet: assert property (go_strobe && (q_en_r == 2'h1 ||
      q_en_r == 2'h2) |=> seq_short) else $error("short packet length");
   a_long_packet: assert property (go_strobe && q_en_r == 2'h3
      |=> seq_long) else $error("combined packet length");
   a_no_enable: assert property (go_strobe && q_en_r == 2'h0
      |=> !pack_busy [*2]) else $error("packet without enables");
   a_rate_readback: assert property (ce && reg_rd && !reg_wr &&
      reg_addr == REG_RATE_RATE_RANGE |=> reg_rdata == sh_rate_r)
      else $error("rate register readback");
   a_accel_readback: assert property (ce && reg_rd && !reg_wr &&
      reg_addr == REG_ACCEL_RATE_RANGE |=> reg_rdata == sh_accel_r)
      else $error("accel register readback");
   a_bw_readback: assert property (ce && reg_rd && !reg_wr &&
      reg_addr == REG_OUT_FILT_BW |=> reg_rdata == sh_bw_r)
      else $error("bandwidth register readback");
   a_cfg_rate_fields: assert property ($past(ce) && !$past(rst) |->
      cfg.rate_output_rate_code == d_rate_r[3:0] &&
      cfg.rate_full_scale_code == d_rate_r[7:5]) else $error("rate cfg");
   a_cfg_accel_fields: assert property ($past(ce) && !$past(rst) |->
      cfg.accel_output_rate_code == d_accel_r[3:0] &&
      cfg.accel_full_scale_code == d_accel_r[7:5]) else $error("accel cfg");
   a_cfg_bw_codes: assert property ($past(ce) && !$past(rst) |->
      cfg.rate_output_filter_bw_code == d_bw_r[3:0] &&
      cfg.accel_output_filter_bw_code == d_bw_r[7:4]) else $error("bw cfg");
endmodule : mofp_assertions
bind mofp_top mofp_assertions #(.DEPTH(DEPTH)) u_chk (
   .sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .sample_strobe(sample_strobe), .sample(sample), .cfg(cfg),
   .sel_bw_dhz(sel_bw_dhz), .sel_delay_dms(sel_delay_dms),
   .sel_noise_bw_dhz(sel_noise_bw_dhz), .pack_busy(pack_busy));
`default_nettype wire

// ===== mofp_host.sv
`timescale 1ns/1ps
`default_nettype none
module mofp_host (
   input wire logic sys_clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // only legal codes
   // Callers pass defined rate, range and filter codes only
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      // Idle bus shows inverted values, never a stale copy
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : write
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask : read
endmodule : mofp_host
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import mofp_pkg::*;
   localparam logic [1:0] FT_ORD [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1,
      2'h2};
   localparam logic [3:0] FT_BW [7] = '{4'h0, 4'hf, 4'h7, 4'h0, 4'h7, 4'h1,
      4'h7};
   localparam int FT_KIND [7] = '{0, 0, 1, 0, 0, 2, 1};
   localparam logic [15:0] FT_VAL [7] = '{16'h1377, 16'h51e3, 16'h0051,
      16'h1345, 16'h00d5, 16'h08bd, 16'h008d};
   logic sys_clk, rst, ce, reg_wr, reg_rd, sample_strobe, pack_busy;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v, hi_v;
   logic [16:0] sel_bw_dhz;
   logic [15:0] sel_delay_dms, sel_noise_bw_dhz;
   mofp_sample_t sample;
   mofp_cfg_t cfg;
   int n_mismatch = 0;
   int comparisons = 0;
   mofp_top #(.DEPTH(32)) u_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sample_strobe(sample_strobe), .sample(sample), .cfg(cfg),
      .sel_bw_dhz(sel_bw_dhz), .sel_delay_dms(sel_delay_dms),
      .sel_noise_bw_dhz(sel_noise_bw_dhz), .pack_busy(pack_busy));
   mofp_host u_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk16
   task automatic chk_bw(input logic [16:0] got, input logic [16:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bw
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      u_host.read(a, rd_v);
      chk8(rd_v, exp);
   endtask : rd_chk
   task automatic chk_count(input logic [15:0] exp);
      u_host.read(REG_QUEUE_COUNT_HI, hi_v);
      u_host.read(REG_QUEUE_COUNT_LO, rd_v);
      chk16({hi_v, rd_v}, exp);
   endtask : chk_count
   // Holding the strobe n cycles offers extra strobes while busy
   task automatic send(input int n);
      int i;
      @(posedge sys_clk);
      sample_strobe <= 1'b1;
      repeat (n) @(posedge sys_clk);
      sample_strobe <= 1'b0;
      for (i = 0; i < 40; i++) begin
         @(posedge sys_clk);
         #1;
         if (pack_busy === 1'b0) break;
      end
      if (i >= 40) begin
         n_mismatch++;
         print_verdict();
      end
   endtask : send
   task automatic check_pkt(input logic [1:0] en, input logic [7:0] hdr);
      logic [127:0] v;
      int n;
      case (en)
         2'h1: v = {hdr, sample.accel, sample.temp, 64'h0};
         2'h2: v = {hdr, sample.rate, sample.temp, 64'h0};
         default: v = {hdr, sample.accel, sample.rate, sample.temp,
            sample.stamp};
      endcase
      n = (en == 2'h3) ? 16 : 8;
      chk_count(16'(n));
      for (int i = 0; i < n; i++) begin
         u_host.read(REG_QUEUE_DATA, rd_v);
         chk8(rd_v, v[127-8*i -: 8]);
      end
      chk_count(16'h0000);
   endtask : check_pkt
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      sample_strobe = 1'b0;
      sample = {16'h8123, 16'h7f01, 16'hfffe, 16'h1234, 16'h8000,
         16'h00ff, 8'hc5, 16'hbeef};
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      rd_chk(REG_RATE_RATE_RANGE, 8'h06);
      rd_chk(REG_ACCEL_RATE_RANGE, 8'h06);
      rd_chk(REG_OUT_FILT_BW, 8'h00);
      rd_chk(REG_QUEUE_DATA, 8'h80);
      chk_count(16'h0000);
      send(1);
      chk_count(16'h0000);
      u_host.write(REG_QUEUE_CFG, 8'h01);
      send(1);
      check_pkt(2'h1, 8'h40);
      u_host.write(REG_QUEUE_CFG, 8'h02);
      send(1);
      check_pkt(2'h2, 8'h20);
      u_host.write(REG_QUEUE_CFG, 8'h03);
      send(1);
      check_pkt(2'h3, 8'h68);
      u_host.write(REG_ACCEL_RATE_RANGE, 8'h6e);
      send(2);
      check_pkt(2'h3, 8'h6a);
      chk8(8'(cfg.accel_full_scale_code), 8'h03);
      u_host.write(REG_RATE_RATE_RANGE, 8'hef);
      u_host.write(REG_QUEUE_CFG, 8'h02);
      send(1);
      check_pkt(2'h2, 8'h21);
      chk8(8'(cfg.rate_full_scale_code), 8'h07);
      u_host.write(REG_RATE_RATE_RANGE, 8'h06);
      u_host.write(REG_ACCEL_FILT_ORDER, 8'h10);
      for (int k = 0; k < 7; k++) begin
         u_host.write(REG_RATE_FILT_ORDER, {4'h0, FT_ORD[k], 2'h0});
         u_host.write(REG_OUT_FILT_BW, {4'h3, FT_BW[k]});
         repeat (4) @(posedge sys_clk);
         #1;
         if (FT_KIND[k] == 0) begin
            chk_bw(sel_bw_dhz, {1'b0, FT_VAL[k]});
         end else if (FT_KIND[k] == 1) begin
            chk16(sel_delay_dms, FT_VAL[k]);
         end else begin
            chk16(sel_noise_bw_dhz, FT_VAL[k]);
         end
      end
      chk8(8'(cfg.accel_output_filter_bw_code), 8'h03);
      chk8(8'(cfg.accel_output_filter_order), 8'h02);
      rd_chk(REG_RATE_FILT_ORDER, 8'h08);
      rd_chk(REG_OUT_FILT_BW, 8'h37);
      chk8(8'(cfg.rate_output_filter_order), 8'h02);
      // The 32 kHz point holds for every order and bandwidth code
      u_host.write(REG_RATE_RATE_RANGE, 8'h01);
      repeat (4) @(posedge sys_clk);
      #1;
      chk_bw(sel_bw_dhz, 17'h14820);
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
